// ### port_io_defs.vh
`ifndef PORT_IO_DEFS_VH
`define PORT_IO_DEFS_VH
`define PIO_DATA_W 16
`define PIO_SEL_W 3
`define PIO_NPORTS 8
`define PIO_DEPTH 256
`define PIO_PTR_W 8
`define PIO_CNT_W 9
`define PIO_FLAG_W 8
`define PIO_FLAGIDX_W 3
`define PIO_FLAG_RST 8'h00
`define PIO_DIV_RST 16'h0000
`define PIO_TX_PORT 3'h0
`define PIO_BAUD_PORT 3'h1
`endif

// ### qio_far_model.sv
`timescale 1ns/1ns
module qio_far_model
(
	input wire i_clk,
	input wire i_slow,
	input wire [7:0] i_push,
	input wire [7:0] i_not_empty,
	input wire [7:0] i_not_full,
	output wire [7:0] o_deq,
	output wire [7:0] o_enq,
	output wire [127:0] o_data,
	output reg o_ready
);
	reg [15:0] cnt = 16'h0000;
	initial o_ready = 1'b1;
	assign o_deq = i_slow ? 8'h00 : i_not_empty;
	assign o_enq = i_push & i_not_full;
	// while no lane enqueues, all lanes carry the inverse so a stale word cannot pass
	assign o_data = {8{(|o_enq) ? cnt : ~cnt}};
	always @(posedge i_clk)
	begin
		o_ready <= i_slow ? ~o_ready : 1'b1;
		if (|o_enq)
			cnt <= cnt + 16'h0001;
	end
endmodule // qio_far_model

// ### qio_props.sv
`timescale 1ns/1ns
module qio_checker
(
	input wire i_clk,
	input wire i_rst,
	input wire i_wr_req,
	input wire [2:0] i_wr_port_select_field,
	input wire [2:0] i_wr_flag_bit_index,
	input wire o_wr_status,
	input wire i_rd_req,
	input wire [2:0] i_rd_flag_bit_index,
	input wire [15:0] o_rd_data,
	input wire o_rd_status,
	input wire [7:0] o_flags,
	input wire [15:0] o_rd_dest,
	input wire i_transmit_buffer_ready,
	input wire o_tx_load,
	input wire o_baud_load
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wr_flag_set_a: assert property (o_wr_status && !i_rd_req
		|=> o_flags[$past(i_wr_flag_bit_index)]) else $error("write flag not set");
	wr_flag_clr_a: assert property (i_wr_req && !o_wr_status && !i_rd_req
		|=> !o_flags[$past(i_wr_flag_bit_index)]) else $error("write flag not cleared");
	wr_gate_a: assert property (o_wr_status |-> i_wr_req)
		else $error("write status without request");
	rd_copy_a: assert property (o_rd_status |=> o_flags[$past(i_rd_flag_bit_index)]
		&& o_rd_dest == $past(o_rd_data)) else $error("read not copied");
	rd_empty_a: assert property (i_rd_req && !o_rd_status
		|=> !o_flags[$past(i_rd_flag_bit_index)] && $stable(o_rd_dest)) else $error("empty read");
	rd_gate_a: assert property (o_rd_status |-> i_rd_req)
		else $error("read status without request");
	tx_ready_a: assert property (o_tx_load |-> $past(i_transmit_buffer_ready))
		else $error("transmit pop while busy");
	baud_pull_a: assert property (o_wr_status && i_wr_port_select_field == 3'h1
		|-> ##[1:3] o_baud_load) else $error("divisor not pulled");
	wr_full_c: cover property (i_wr_req && !o_wr_status);
	rd_empty_c: cover property (i_rd_req && !o_rd_status);
	tx_load_c: cover property (o_tx_load);
endmodule // qio_checker
bind queued_io_port_control qio_checker chk_u (.*);

// ### queued_io_port_control.v
`timescale 1ns/1ns
`include "port_io_defs.vh"
// Operation
// R1 - write select 000..111 means output ports 1..8
// R2 - write sets or clears named flag bit
// R3 - each output port has 256x16 queue
// R4 - not full: enqueue, status 1 same cycle
// R5 - full: block enqueue, status 0
// R6 - output device dequeues only when not empty
// R7 - port 1 to transmitter, port 2 divisor
// R8 - transmit dequeue needs data and ready high
// R9 - divisor dequeued whenever port 2 has data
// R10 - read select 000..111 means input ports 0..7
// R11 - read copies data, flag gets status
// R12 - read exchanged in first execute stage
// R13 - eight input ports, each own queue
// R14 - input device writes only when not full
// R15 - empty read: status 0; else dequeue, 1
// R16 - input queues also 256x16
module queued_io_port_control
(
	input wire i_clk,
	input wire i_rst,
	input wire i_wr_req,
	input wire [`PIO_SEL_W-1:0] i_wr_port_select_field,
	input wire [`PIO_FLAGIDX_W-1:0] i_wr_flag_bit_index,
	input wire [`PIO_DATA_W-1:0] i_wr_data,
	output wire o_wr_status,
	input wire i_rd_req,
	input wire [`PIO_SEL_W-1:0] i_rd_port_select_field,
	input wire [`PIO_FLAGIDX_W-1:0] i_rd_flag_bit_index,
	output wire [`PIO_DATA_W-1:0] o_rd_data,
	output wire o_rd_status,
	output reg [`PIO_FLAG_W-1:0] o_flags,
	output reg [`PIO_DATA_W-1:0] o_rd_dest,
	input wire [`PIO_NPORTS-1:0] i_out_deq,
	output reg [`PIO_NPORTS-1:0] o_out_not_empty,
	output reg [`PIO_NPORTS*`PIO_DATA_W-1:0] o_out_data,
	input wire [`PIO_NPORTS-1:0] i_in_enq,
	input wire [`PIO_NPORTS*`PIO_DATA_W-1:0] i_in_data,
	output reg [`PIO_NPORTS-1:0] o_in_not_full,
	input wire i_transmit_buffer_ready,
	output reg o_tx_load,
	output reg [`PIO_DATA_W-1:0] o_tx_data,
	output reg [`PIO_DATA_W-1:0] o_baud_divisor,
	output reg o_baud_load
);

// status must answer in the same cycle, so status and read data are
// combinational from queue state; everything else is registered.
// o_wr_status/o_rd_status/o_rd_data are the documented same-cycle exchange.

reg [`PIO_DATA_W-1:0] out_mem [0:`PIO_NPORTS*`PIO_DEPTH-1]; // [R3]
reg [`PIO_DATA_W-1:0] in_mem [0:`PIO_NPORTS*`PIO_DEPTH-1]; // [R16] [R13]
reg [`PIO_PTR_W-1:0] out_wp [0:`PIO_NPORTS-1];
reg [`PIO_PTR_W-1:0] out_rp [0:`PIO_NPORTS-1];
reg [`PIO_CNT_W-1:0] out_cnt [0:`PIO_NPORTS-1];
reg [`PIO_PTR_W-1:0] in_wp [0:`PIO_NPORTS-1];
reg [`PIO_PTR_W-1:0] in_rp [0:`PIO_NPORTS-1];
reg [`PIO_CNT_W-1:0] in_cnt [0:`PIO_NPORTS-1];

function [`PIO_NPORTS-1:0] onehot;
	input [`PIO_SEL_W-1:0] sel;
	begin
		onehot = {{(`PIO_NPORTS-1){1'b0}}, 1'b1} << sel;
	end
endfunction

// select code 000 is port 1; vector index 0 holds port 1
wire [`PIO_NPORTS-1:0] wr_hot = onehot(i_wr_port_select_field); // [R1]
// select code 000 is port 0; index equals port number
wire [`PIO_NPORTS-1:0] rd_hot = onehot(i_rd_port_select_field); // [R10]

wire [`PIO_NPORTS-1:0] out_full;
wire [`PIO_NPORTS-1:0] out_empty;
wire [`PIO_NPORTS-1:0] in_full;
wire [`PIO_NPORTS-1:0] in_empty;
wire [`PIO_NPORTS-1:0] out_push;
wire [`PIO_NPORTS-1:0] out_pop;
wire [`PIO_NPORTS-1:0] in_push;
wire [`PIO_NPORTS-1:0] in_pop;
wire tx_pop;
wire baud_pop;

// serial adapter owns the dequeue side of ports 1 and 2
assign tx_pop = ~out_empty[`PIO_TX_PORT] & i_transmit_buffer_ready; // [R7] [R8]
assign baud_pop = ~out_empty[`PIO_BAUD_PORT]; // [R7] [R9]

assign o_wr_status = i_wr_req & ~out_full[i_wr_port_select_field]; // [R4] [R5]
assign o_rd_status = i_rd_req & ~in_empty[i_rd_port_select_field]; // [R15] [R12]
assign o_rd_data = in_mem[{i_rd_port_select_field, in_rp[i_rd_port_select_field]}]; // [R11]

genvar g;
generate
	for (g = 0; g < `PIO_NPORTS; g = g + 1)
	begin : q
		// a genvar cannot be part-selected, so the port code gets its own constant
		localparam [`PIO_SEL_W-1:0] PORT_CODE = g;
		assign out_full[g] = out_cnt[g] == `PIO_DEPTH;
		assign out_empty[g] = out_cnt[g] == {`PIO_CNT_W{1'b0}};
		assign in_full[g] = in_cnt[g] == `PIO_DEPTH;
		assign in_empty[g] = in_cnt[g] == {`PIO_CNT_W{1'b0}};
		assign out_push[g] = o_wr_status & wr_hot[g]; // [R4] [R5]
		// a device dequeue on an empty queue is ignored
		if (g == `PIO_TX_PORT)
		begin : tx
			assign out_pop[g] = tx_pop; // [R8]
		end
		else if (g == `PIO_BAUD_PORT)
		begin : bd
			assign out_pop[g] = baud_pop; // [R9]
		end
		else
		begin : gen
			assign out_pop[g] = i_out_deq[g] & ~out_empty[g]; // [R6]
		end
		assign in_push[g] = i_in_enq[g] & ~in_full[g]; // [R14]
		assign in_pop[g] = o_rd_status & rd_hot[g]; // [R15]

		always @(posedge i_clk or posedge i_rst)
		begin
			if (i_rst)
			begin
				out_wp[g] <= {`PIO_PTR_W{1'b0}};
				out_rp[g] <= {`PIO_PTR_W{1'b0}};
				out_cnt[g] <= {`PIO_CNT_W{1'b0}};
				in_wp[g] <= {`PIO_PTR_W{1'b0}};
				in_rp[g] <= {`PIO_PTR_W{1'b0}};
				in_cnt[g] <= {`PIO_CNT_W{1'b0}};
				o_out_not_empty[g] <= 1'b0;
				o_in_not_full[g] <= 1'b0;
				o_out_data[g*`PIO_DATA_W +: `PIO_DATA_W] <= {`PIO_DATA_W{1'b0}};
			end
			else
			begin
				if (out_push[g])
					out_wp[g] <= out_wp[g] + 8'h01;
				if (out_pop[g])
					out_rp[g] <= out_rp[g] + 8'h01;
				if (out_push[g] & ~out_pop[g])
					out_cnt[g] <= out_cnt[g] + 9'h001;
				else if (out_pop[g] & ~out_push[g])
					out_cnt[g] <= out_cnt[g] - 9'h001;
				if (in_push[g])
					in_wp[g] <= in_wp[g] + 8'h01;
				if (in_pop[g])
					in_rp[g] <= in_rp[g] + 8'h01;
				if (in_push[g] & ~in_pop[g])
					in_cnt[g] <= in_cnt[g] + 9'h001;
				else if (in_pop[g] & ~in_push[g])
					in_cnt[g] <= in_cnt[g] - 9'h001;
				// registered status: lags queue state by one cycle
				o_out_not_empty[g] <= ~out_empty[g];
				o_in_not_full[g] <= ~in_full[g];
				if (out_pop[g])
					o_out_data[g*`PIO_DATA_W +: `PIO_DATA_W] <=
						out_mem[{PORT_CODE, out_rp[g]}];
			end
		end
	end
endgenerate

// memories carry no reset so they can map to block ram
always @(posedge i_clk)
begin
	if (o_wr_status)
		out_mem[{i_wr_port_select_field, out_wp[i_wr_port_select_field]}] <= i_wr_data; // [R4]
end

integer k;
always @(posedge i_clk)
begin
	for (k = 0; k < `PIO_NPORTS; k = k + 1)
	begin
		if (in_push[k])
			in_mem[{k[2:0], in_wp[k]}] <= i_in_data[k*`PIO_DATA_W +: `PIO_DATA_W];
	end
end

always @(posedge i_clk or posedge i_rst)
begin
	if (i_rst)
	begin
		o_flags <= `PIO_FLAG_RST;
		o_rd_dest <= {`PIO_DATA_W{1'b0}};
		o_tx_load <= 1'b0;
		o_tx_data <= {`PIO_DATA_W{1'b0}};
		o_baud_load <= 1'b0;
		o_baud_divisor <= `PIO_DIV_RST;
	end
	else
	begin
		// read applied after write if both name the same flag bit
		if (i_wr_req)
			o_flags[i_wr_flag_bit_index] <= o_wr_status; // [R2]
		if (i_rd_req)
			o_flags[i_rd_flag_bit_index] <= o_rd_status; // [R11]
		if (o_rd_status)
			o_rd_dest <= o_rd_data; // [R11]
		o_tx_load <= tx_pop; // [R8]
		if (tx_pop)
			o_tx_data <= out_mem[{`PIO_TX_PORT, out_rp[`PIO_TX_PORT]}];
		o_baud_load <= baud_pop; // [R9]
		if (baud_pop)
			o_baud_divisor <= out_mem[{`PIO_BAUD_PORT, out_rp[`PIO_BAUD_PORT]}];
	end
end

endmodule // queued_io_port_control

// ### queued_io_port_control_tb_top.sv
`timescale 1ns/1ns
module queued_io_port_control_tb_top;
	reg i_clk = 0, i_rst = 1, wq = 0, rq = 0, slow = 0;
	reg [2:0] ws = 0, rs = 0, ri = 0;
	reg [15:0] wd = 0;
	reg [7:0] push = 0;
	wire [7:0] deq, ne, nf, enq, fl;
	wire [127:0] od, idt;
	wire [15:0] rd, dest, txd, bd;
	wire wst, rds, transmit_buffer_ready, txl, bl;
	integer error_cnt = 0, tests_run = 0, i;
	queued_io_port_control dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_wr_req(wq),
		.i_wr_port_select_field(ws), .i_wr_flag_bit_index(ws), .i_wr_data(wd),
		.o_wr_status(wst), .i_rd_req(rq), .i_rd_port_select_field(rs),
		.i_rd_flag_bit_index(ri), .o_rd_data(rd), .o_rd_status(rds), .o_flags(fl),
		.o_rd_dest(dest), .i_out_deq(deq), .o_out_not_empty(ne), .o_out_data(od),
		.i_in_enq(enq), .i_in_data(idt), .o_in_not_full(nf), .i_transmit_buffer_ready(transmit_buffer_ready),
		.o_tx_load(txl), .o_tx_data(txd), .o_baud_divisor(bd), .o_baud_load(bl));
	qio_far_model dev_u (.i_clk(i_clk), .i_slow(slow), .i_push(push), .i_not_empty(ne),
		.i_not_full(nf), .o_deq(deq), .o_enq(enq), .o_data(idt), .o_ready(transmit_buffer_ready));
	initial
	begin
		forever #50 i_clk = ~i_clk;
	end
	task chk(input [8*6-1:0] nm, input [15:0] got, input [15:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	end
	endtask
	task wr(input [2:0] s, input [15:0] d, input e);
	begin
		@(negedge i_clk);
		wq = 1;
		ws = s;
		wd = d;
		#10 chk("wstat", wst, e);
		@(negedge i_clk);
		wq = 0;
		chk("wflag", fl[s], e);
	end
	endtask
	task rdp(input [2:0] s, input [15:0] d, input e);
	begin
		@(negedge i_clk);
		rq = 1;
		rs = s;
		ri = ~s;
		#10 chk("rstat", rds, e);
		@(negedge i_clk);
		rq = 0;
		chk("rflag", fl[~s], e);
		if (e)
			chk("rdest", dest, d);
	end
	endtask
	task t_map;
	begin
		for (i = 0; i < 8; i = i + 1)
			wr(i[2:0], 16'h1000 + i[15:0], 1);
		repeat (6) @(negedge i_clk);
		for (i = 2; i < 8; i = i + 1)
			chk("odata", od[i*16 +: 16], 16'h1000 + i[15:0]);
		chk("txdat", txd, 16'h1000);
		chk("divis", bd, 16'h1001);
	end
	endtask
	task t_full;
	begin
		slow = 1;
		wr(3'h0, 16'hABCD, 1);
		for (i = 0; i < 256; i = i + 1)
			wr(3'h7, i[15:0], 1);
		wr(3'h7, 16'hFFFF, 0);
		slow = 0;
		repeat (600) @(negedge i_clk);
		chk("last", od[127:112], 16'h00FF);
		chk("txslw", txd, 16'hABCD);
	end
	endtask
	task t_in;
	begin
		rdp(3'h3, 0, 0);
		push = 8'h20;
		repeat (2) @(negedge i_clk);
		push = 8'h00;
		rdp(3'h5, 0, 1);
		rdp(3'h5, 1, 1);
		rdp(3'h5, 0, 0);
		push = 8'h01;
		for (i = 0; i < 400 && nf[0] !== 1'b0; i = i + 1)
			@(negedge i_clk);
		push = 8'h00;
		for (i = 0; i < 256; i = i + 1)
			rdp(3'h0, i[15:0] + 16'h0002, 1);
		rdp(3'h0, 0, 0);
	end
	endtask
	task end_sim;
	begin
		$display("errors %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	initial
	begin
		#1000000;
		error_cnt = error_cnt + 1;
		end_sim;
	end
	initial
	begin
		repeat (16) @(negedge i_clk);
		i_rst = 0;
		t_map;
		t_full;
		t_in;
		end_sim;
	end
endmodule // queued_io_port_control_tb_top
